// ===== hdl/valve_ctrl_map.vh
// Constants for the valve closed-loop controller: parameter word indices,
// field positions, reset values and timing counts.
// Assumes a 100 MHz ref_clk.
`ifndef VALVE_CTRL_MAP_VH
`define VALVE_CTRL_MAP_VH

`define CLK_HZ          100000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define CB_WINDOW_MS    100
`define CB_WINDOW_CYC   (`CB_WINDOW_MS * `CYC_PER_MS)
`define CTRL_PERIOD_US  100
`define CTRL_PERIOD_CYC (`CTRL_PERIOD_US * (`CLK_HZ / 1000000))
`define RAMP_MAX_MS     16'hc738
`define RAMP_FS         34'h000008000

`define ADC_MID         10'h200
`define LIVE_ZERO_CODE  10'h0cd
`define GAIN_SHIFT      8
`define I_LIM           36'sh07fffffff

`define RNG_VOLT        2'h0
`define RNG_0_20        2'h1
`define RNG_4_20        2'h2

`define MODE_POS        2'h0
`define MODE_SPEED      2'h1
`define MODE_PRES       2'h2
`define MODE_FLOW       2'h3

`define PRM_CFG         4'h0
`define PRM_RAMP_UP     4'h1
`define PRM_RAMP_DN     4'h2
`define PRM_KP          4'h3
`define PRM_KI          4'h4
`define PRM_KD          4'h5
`define PRM_SP_SCALE    4'h6
`define PRM_ACT_SCALE   4'h7
`define PRM_FIX_CUR     4'h8
`define PRM_COUNT       9

`define CFG_MODE_LSB    0
`define CFG_BYPASS      2
`define CFG_SP_SRC      3
`define CFG_CB_EN       4
`define CFG_ERR_FIX     5
`define CFG_RNG1_LSB    8
`define CFG_RNG2_LSB    10

`define CFG_RST         16'h0800
`define RAMP_RST        16'h0000
`define KP_RST          16'h0100
`define KI_RST          16'h0000
`define KD_RST          16'h0000
`define SCALE_RST       16'h0100
`define FIX_CUR_RST     16'h0000

`define NV_RESTORE      2'h0
`define NV_IDLE         2'h1
`define NV_SAVE         2'h2

`endif

// ===== hdl/setpoint_ramp.v
// Linear set-point ramp with separate rise and fall times in ms.
// Assumes target is held steady between updates; one clock domain.
`timescale 1ns/1ps
`include "valve_ctrl_map.vh"
module setpoint_ramp #(
	parameter W = 16
) (
	input  wire                ref_clk,
	input  wire                rst_b,
	input  wire                clk_en,
	input  wire signed [W-1:0] target,
	input  wire        [15:0]  up_ms,
	input  wire        [15:0]  down_ms,
	output wire signed [W-1:0] value
);
	reg signed [W-1:0] value_q;
	reg        [33:0]  acc_q;
	wire       [33:0]  cpm = `CYC_PER_MS;
	wire               rising = target > value_q;
	// Magnitude grows: the rise time applies
	wire               away = rising ? (value_q >= 0) : (value_q <= 0);
	wire       [15:0]  t_raw = away ? up_ms : down_ms;
	wire       [15:0]  t_ms = (t_raw > `RAMP_MAX_MS) ? `RAMP_MAX_MS : t_raw;
	wire       [33:0]  lim = {18'h00000, t_ms} * cpm;
	wire       [33:0]  acc_sum = acc_q + `RAMP_FS;
	wire signed [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

	assign value = value_q;

	// Full positive scale is crossed in t_ms; one LSB step at most per clock, except a jump straight to target when t_ms is zero
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			value_q <= {W{1'b0}};
			acc_q   <= 34'h000000000;
		end else if (clk_en) begin
			if (value_q == target) begin
				acc_q <= 34'h000000000;
			end else if (t_ms == 16'h0000) begin
				value_q <= target; // [R6]
				acc_q   <= 34'h000000000;
			end else if (acc_sum >= lim) begin
				acc_q   <= acc_sum - lim;
				value_q <= rising ? value_q + one : value_q - one; // [R6]
			end else begin
				acc_q <= acc_sum;
			end
		end
	end
endmodule

// ===== hdl/valve_closed_loop_controller.v
// Closed-loop core of a proportional-valve amplifier: input conversion,
// scaling, ramp, PID, bypass, cable-break watch, error reaction,
// parameter persistence and signal recording.
// Assumes an external ADC giving 10-bit codes synchronous to ref_clk,
// a fieldbus stack writing set-point and parameter words, and an
// external non-volatile store answering nv_req with a one-cycle nv_ack.
// Functional notes
// R1: Analogue inputs arrive as 10-bit samples
// R2: Inputs ranged as voltage, 0-20 or 4-20 mA
// R3: Set-point and parameters come over fieldbus
// R4: Mode picks position, speed, pressure, flow
// R5: Set-point and actual scaled to chosen unit
// R6: Linear ramp, separate rise/fall up to 51 s
// R7: Difference is ramped set-point minus actual
// R8: PID law with adjustable gains
// R9: Bypass makes current follow set-point directly
// R10: Save parameters on request, restore at power-up
// R11: Record signals on common time base
// R12: Cable break blocks output, raises error
// R13: Watch only if enabled and 4-20 mA
// R14: Break flagged after about 100 ms
// R15: Error reaction: block or fixed current
// R16: Below 4 mA code for window is break
`timescale 1ns/1ps
`include "valve_ctrl_map.vh"
module valve_closed_loop_controller #(
	parameter        [31:0] CB_WIN_CYC = `CB_WINDOW_CYC,
	parameter        [31:0] CTRL_CYC   = `CTRL_PERIOD_CYC,
	parameter               REC_AW     = 4
) (
	input  wire               ref_clk,
	input  wire               rst_b,
	input  wire               clk_en,
	input  wire               bus_sp_wr,
	input  wire        [15:0] bus_sp,
	input  wire               param_wr,
	input  wire        [3:0]  param_addr,
	input  wire        [15:0] param_wdata,
	output reg         [15:0] param_rdata,
	input  wire               nv_save_req,
	output wire               nv_req,
	output wire               nv_we,
	output wire        [3:0]  nv_addr,
	output reg         [15:0] nv_wdata,
	input  wire               nv_ack,
	input  wire        [15:0] nv_rdata,
	output wire               nv_busy,
	input  wire        [9:0]  ain1_code,
	input  wire        [9:0]  ain2_code,
	input  wire               fault_in,
	input  wire               fault_supply_ok,
	input  wire               err_ack,
	output reg         [11:0] sol_a_cur,
	output reg         [11:0] sol_b_cur,
	output reg                sol_en,
	output reg                error_out,
	output reg                cable_break,
	input  wire               rec_start,
	input  wire  [REC_AW-1:0] rec_rd_idx,
	output reg         [63:0] rec_rdata,
	output reg                rec_busy,
	output reg                rec_done
);
	localparam        NPRM     = `PRM_COUNT;
	localparam [23:0] CB_LAST  = CB_WIN_CYC[23:0] - 24'h000001;
	localparam [15:0] CTL_LAST = CTRL_CYC[15:0] - 16'h0001;
	localparam        REC_N    = 1 << REC_AW;

	function [15:0] prm_rst;
		input [3:0] i;
		begin
			case (i)
				`PRM_CFG:       prm_rst = `CFG_RST;
				`PRM_RAMP_UP:   prm_rst = `RAMP_RST;
				`PRM_RAMP_DN:   prm_rst = `RAMP_RST;
				`PRM_KP:        prm_rst = `KP_RST;
				`PRM_KI:        prm_rst = `KI_RST;
				`PRM_KD:        prm_rst = `KD_RST;
				`PRM_FIX_CUR:   prm_rst = `FIX_CUR_RST;
				default:        prm_rst = `SCALE_RST;
			endcase
		end
	endfunction

	function [15:0] sat16;
		input signed [35:0] v;
		begin
			if (v > 36'sh000007fff)
				sat16 = 16'h7fff;
			else if (v < -36'sh000008000)
				sat16 = 16'h8000;
			else
				sat16 = v[15:0];
		end
	endfunction

	function [15:0] scale;
		input signed [15:0] x;
		input        [15:0] k;
		reg   signed [35:0] p;
		begin
			p = x * $signed({1'b0, k});
			scale = sat16(p >>> `GAIN_SHIFT);
		end
	endfunction

	// Parameter file and persistence sequencer
	reg  [1:0]        nv_state_q;
	reg  [3:0]        nv_idx_q;
	wire [16*NPRM-1:0] prm_flat;
	wire              nv_restore = (nv_state_q == `NV_RESTORE);
	wire              nv_save = (nv_state_q == `NV_SAVE);
	wire              bus_wr_ok = param_wr && (nv_state_q == `NV_IDLE);
	wire              nv_last = (nv_idx_q == NPRM - 1);

	genvar g;
	generate
		for (g = 0; g < NPRM; g = g + 1) begin : prm_gen
			reg [15:0] word_q;
			assign prm_flat[g*16 +: 16] = word_q;
			always @(posedge ref_clk) begin
				if (!rst_b)
					word_q <= prm_rst(g);
				else if (clk_en) begin
					if (nv_restore && nv_ack && nv_idx_q == g)
						word_q <= nv_rdata; // [R10]
					else if (bus_wr_ok && param_addr == g)
						word_q <= param_wdata; // [R3]
				end
			end
		end
	endgenerate

	function [15:0] prm_word;
		input [3:0] i;
		begin
			prm_word = (i < NPRM) ? prm_flat[i*16 +: 16] : 16'h0000;
		end
	endfunction

	wire [15:0] cfg     = prm_flat[`PRM_CFG*16 +: 16];
	wire [1:0]  mode    = cfg[`CFG_MODE_LSB +: 2];
	wire        bypass  = cfg[`CFG_BYPASS];
	wire        sp_src  = cfg[`CFG_SP_SRC];
	wire        cb_en   = cfg[`CFG_CB_EN];
	wire        err_fix = cfg[`CFG_ERR_FIX];
	wire [1:0]  rng2    = cfg[`CFG_RNG2_LSB +: 2];
	wire [15:0] kp      = prm_flat[`PRM_KP*16 +: 16];
	wire [15:0] ki      = prm_flat[`PRM_KI*16 +: 16];
	wire [15:0] kd      = prm_flat[`PRM_KD*16 +: 16];

	assign nv_req  = !(nv_state_q == `NV_IDLE);
	assign nv_we   = nv_save;
	assign nv_addr = nv_idx_q;
	assign nv_busy = nv_req;

	// Restore runs once after reset; bus writes are refused meanwhile
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			nv_state_q <= `NV_RESTORE;
			nv_idx_q   <= 4'h0;
			nv_wdata   <= 16'h0000;
		end else if (clk_en) begin
			case (nv_state_q)
				`NV_RESTORE, `NV_SAVE: begin
					if (nv_ack) begin
						nv_idx_q   <= nv_last ? 4'h0 : nv_idx_q + 4'h1;
						nv_wdata   <= prm_word(nv_idx_q + 4'h1);
						nv_state_q <= nv_last ? `NV_IDLE : nv_state_q; // [R10]
					end
				end
				`NV_IDLE: begin
					if (nv_save_req) begin
						nv_state_q <= `NV_SAVE; // [R10]
						nv_idx_q   <= 4'h0;
						nv_wdata   <= prm_word(4'h0);
					end
				end
				default: nv_state_q <= `NV_IDLE;
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b)
			param_rdata <= 16'h0000;
		else if (clk_en)
			param_rdata <= prm_word(param_addr);
	end

	// Analogue input conversion to a common signed scale
	wire [19:0] ain_codes = {ain2_code, ain1_code};
	wire [3:0]  rngs = {rng2, cfg[`CFG_RNG1_LSB +: 2]};
	wire [31:0] norm_flat;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ain_gen
			wire [9:0]  c = ain_codes[g*10 +: 10];
			wire [9:0]  c_lz = c - `LIVE_ZERO_CODE;
			reg  [15:0] n;
			reg  [15:0] n_q;
			assign norm_flat[g*16 +: 16] = n_q;
			always @* begin
				case (rngs[g*2 +: 2])
					`RNG_VOLT: n = {c ^ `ADC_MID, 6'h00}; // [R1] [R2]
					`RNG_0_20: n = {1'b0, c, 5'h00}; // [R2]
					`RNG_4_20: n = (c < `LIVE_ZERO_CODE) ? 16'h0000 : {1'b0, c_lz, 5'h00}; // [R2]
					default:   n = 16'h0000;
				endcase
			end
			always @(posedge ref_clk) begin
				if (!rst_b)
					n_q <= 16'h0000;
				else if (clk_en)
					n_q <= n;
			end
		end
	endgenerate

	// Set-point source, scaling and ramp
	reg  signed [15:0] bus_sp_q;
	reg  signed [15:0] sp_q;
	reg  signed [15:0] act_q;
	wire signed [15:0] sp_ramp;
	wire signed [15:0] sp_raw = sp_src ? norm_flat[15:0] : bus_sp_q;

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			bus_sp_q <= 16'h0000;
			sp_q     <= 16'h0000;
			act_q    <= 16'h0000;
		end else if (clk_en) begin
			if (bus_sp_wr)
				bus_sp_q <= bus_sp; // [R3]
			sp_q  <= scale(sp_raw, prm_flat[`PRM_SP_SCALE*16 +: 16]); // [R5]
			act_q <= scale(norm_flat[31:16], prm_flat[`PRM_ACT_SCALE*16 +: 16]); // [R5]
		end
	end

	setpoint_ramp #(
		.W       (16)
	) u_ramp (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.target  (sp_q),
		.up_ms   (prm_flat[`PRM_RAMP_UP*16 +: 16]),
		.down_ms (prm_flat[`PRM_RAMP_DN*16 +: 16]),
		.value   (sp_ramp)
	);

	// PID on a fixed control tick
	reg  [15:0]        ctl_cnt_q;
	reg  signed [16:0] e_prev_q;
	reg  signed [35:0] i_acc_q;
	reg  signed [15:0] cmd_q;
	wire               tick = (ctl_cnt_q == CTL_LAST);
	wire signed [16:0] e = sp_ramp - act_q; // [R7]
	wire signed [17:0] de = e - e_prev_q;
	wire               i_on = (mode != `MODE_POS); // [R4]
	wire               d_on = (mode == `MODE_POS) || (mode == `MODE_PRES); // [R4]
	wire signed [35:0] p_t = e * $signed({1'b0, kp}); // [R8]
	wire signed [35:0] d_t = d_on ? de * $signed({1'b0, kd}) : 36'sh000000000;
	wire signed [35:0] i_sum = i_acc_q + e * $signed({1'b0, ki});
	wire signed [35:0] i_d = (i_sum > `I_LIM) ? `I_LIM : (i_sum < -`I_LIM) ? -`I_LIM : i_sum;
	wire signed [35:0] u_sum = p_t + i_acc_q + d_t; // [R8]
	wire [15:0]        diff_sat = sat16({{19{e[16]}}, e});

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			ctl_cnt_q <= 16'h0000;
			e_prev_q  <= 17'h00000;
			i_acc_q   <= 36'sh000000000;
			cmd_q     <= 16'h0000;
		end else if (clk_en) begin
			ctl_cnt_q <= tick ? 16'h0000 : ctl_cnt_q + 16'h0001;
			if (tick) begin
				e_prev_q <= e;
				if (bypass) begin
					cmd_q   <= sp_ramp; // [R9]
					i_acc_q <= 36'sh000000000;
				end else begin
					cmd_q   <= sat16(u_sum >>> `GAIN_SHIFT); // [R7] [R8]
					i_acc_q <= i_on ? i_d : 36'sh000000000;
				end
			end
		end
	end

	// Cable-break watch on input 2 and error reaction
	reg  [23:0] cb_cnt_q;
	wire        cb_mon = cb_en && (rng2 == `RNG_4_20); // [R13]
	wire        cb_low = ain2_code < `LIVE_ZERO_CODE; // [R16]
	wire        cb_hit = cb_mon && cb_low && (cb_cnt_q == CB_LAST); // [R14]
	wire        fix_ok = fault_in && err_fix && fault_supply_ok && !cable_break;
	wire        block = cable_break || (fault_in && !fix_ok) || nv_restore; // [R12] [R15]
	wire [16:0] neg = 17'h00000 - {cmd_q[15], cmd_q};

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			cb_cnt_q    <= 24'h000000;
			cable_break <= 1'b0;
			error_out   <= 1'b0;
			sol_a_cur   <= 12'h000;
			sol_b_cur   <= 12'h000;
			sol_en      <= 1'b0;
		end else if (clk_en) begin
			if (cb_mon && cb_low)
				cb_cnt_q <= cb_hit ? cb_cnt_q : cb_cnt_q + 24'h000001; // [R16]
			else
				cb_cnt_q <= 24'h000000;
			if (cb_hit)
				cable_break <= 1'b1; // [R12]
			else if (err_ack)
				cable_break <= 1'b0;
			error_out <= cable_break || cb_hit || fault_in; // [R12]
			if (block) begin
				sol_a_cur <= 12'h000; // [R12] [R15]
				sol_b_cur <= 12'h000;
				sol_en    <= 1'b0;
			end else if (fix_ok) begin
				sol_a_cur <= prm_flat[`PRM_FIX_CUR*16 +: 12]; // [R15]
				sol_b_cur <= 12'h000;
				sol_en    <= 1'b1;
			end else begin
				sol_a_cur <= cmd_q[15] ? 12'h000 : cmd_q[14:3];
				sol_b_cur <= !cmd_q[15] ? 12'h000 : neg[15] ? 12'hfff : neg[14:3];
				sol_en    <= 1'b1;
			end
		end
	end

	// Signal recording, one entry per control tick
	reg [63:0]       rec_mem [0:REC_N-1];
	reg [REC_AW-1:0] rec_ptr_q;

	always @(posedge ref_clk) begin
		if (clk_en && rec_busy && tick)
			rec_mem[rec_ptr_q] <= {sp_ramp, act_q, diff_sat, cmd_q}; // [R11]
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			rec_ptr_q <= {REC_AW{1'b0}};
			rec_busy  <= 1'b0;
			rec_done  <= 1'b0;
			rec_rdata <= 64'h0000000000000000;
		end else if (clk_en) begin
			rec_rdata <= rec_mem[rec_rd_idx];
			if (rec_start) begin
				rec_ptr_q <= {REC_AW{1'b0}};
				rec_busy  <= 1'b1;
				rec_done  <= 1'b0;
			end else if (rec_busy && tick) begin
				rec_ptr_q <= rec_ptr_q + {{(REC_AW-1){1'b0}}, 1'b1};
				if (rec_ptr_q == REC_N - 1) begin
					rec_busy <= 1'b0; // [R11]
					rec_done <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== dv/valve_ctrl_chk.sv
// Checker for the valve controller: output blocking, store handshake, break timing.
// Assumes it is bound to valve_closed_loop_controller and sees only its ports.
`timescale 1ns/1ps
module valve_ctrl_chk #(
	parameter [31:0] CB_WIN_CYC = 32'd50
) (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        clk_en,
	input wire logic [9:0]  ain2_code,
	input wire logic        nv_req,
	input wire logic        nv_we,
	input wire logic [3:0]  nv_addr,
	input wire logic        nv_ack,
	input wire logic [11:0] sol_a_cur,
	input wire logic [11:0] sol_b_cur,
	input wire logic        sol_en,
	input wire logic        error_out,
	input wire logic        cable_break,
	input wire logic        rec_done
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic [31:0] low_run_q;
	// Consecutive enabled cycles with the sensor code under the 4 mA code
	always @(posedge ref_clk) begin
		if (!rst_b || ain2_code >= 10'h0cd)
			low_run_q <= 32'h0;
		else if (clk_en)
			low_run_q <= low_run_q + 32'h1;
	end
	a_break_err_same: assert property ($rose(cable_break) |-> error_out)
		else $error("cable break without error output");
	a_break_blocks: assert property (cable_break && clk_en |=> sol_a_cur == 12'h0
		&& sol_b_cur == 12'h0)
		else $error("solenoid current during cable break");
	a_break_not_early: assert property ($rose(cable_break) |-> low_run_q >= CB_WIN_CYC - 1)
		else $error("cable break flagged before window");
	a_nv_hold: assert property (nv_req && !nv_ack |=> nv_req && $stable(nv_addr)
		&& $stable(nv_we))
		else $error("store request dropped before ack");
	a_nv_step: assert property (clk_en && nv_req && nv_ack && nv_addr != 4'h8
		|=> nv_addr == $past(nv_addr) + 4'h1)
		else $error("store index did not advance");
	a_nv_last: assert property (clk_en && nv_req && nv_ack && nv_addr == 4'h8 |=> !nv_req)
		else $error("store transfer ran past last word");
	a_restore_block: assert property (nv_req && !nv_we |-> !sol_en && sol_a_cur == 12'h0
		&& sol_b_cur == 12'h0)
		else $error("output active during restore");
	a_one_side: assert property (!(sol_a_cur != 12'h0 && sol_b_cur != 12'h0))
		else $error("both solenoids driven");
	c_break: cover property ($rose(cable_break));
	c_save: cover property (nv_req && nv_we && nv_ack);
	c_rec: cover property ($rose(rec_done));
endmodule
bind valve_closed_loop_controller valve_ctrl_chk #(.CB_WIN_CYC(CB_WIN_CYC)) chk (.ref_clk,
	.rst_b, .clk_en, .ain2_code, .nv_req, .nv_we, .nv_addr, .nv_ack, .sol_a_cur,
	.sol_b_cur, .sol_en, .error_out, .cable_break, .rec_done);

// ===== dv/nv_store_model.sv
// Behavioural non-volatile parameter store with adjustable answer delay.
// Assumes the controller holds request, index and data until the ack pulse.
`timescale 1ns/1ps
module nv_store_model (
	input  wire logic        ref_clk,
	input  wire logic        nv_req,
	input  wire logic        nv_we,
	input  wire logic [3:0]  nv_addr,
	input  wire logic [15:0] nv_wdata,
	output logic             nv_ack,
	output logic [15:0]      nv_rdata
);
	logic [15:0] mem [0:15];
	int          lat = 1;
	int          wait_q = 0;
	initial begin
		nv_ack = 1'b0;
		nv_rdata = 16'h0;
		for (int i = 0; i < 16; i++)
			mem[i] = 16'h0;
		mem[0] = 16'h0810;
		mem[3] = 16'h0100;
		mem[6] = 16'h0100;
		mem[7] = 16'h0100;
	end
	// Read data only valid with the ack, scrambled otherwise
	always @(posedge ref_clk) begin
		nv_ack <= 1'b0;
		nv_rdata <= ~nv_rdata;
		if (nv_req && !nv_ack) begin
			if (wait_q >= lat) begin
				wait_q <= 0;
				nv_ack <= 1'b1;
				if (nv_we)
					mem[nv_addr] <= nv_wdata;
				else
					nv_rdata <= mem[nv_addr];
			end else
				wait_q <= wait_q + 1;
		end
	end
endmodule

// ===== dv/tb.sv
// Testbench for the valve controller: parameter access, store, loop, break, fault.
// Assumes short counts for break window and control tick; inputs change at negedge.
`timescale 1ns/1ps
module tb;
	logic ref_clk = 0, rst_b = 0, clk_en = 1, bus_sp_wr = 0, param_wr = 0, nv_save_req = 0;
	logic fault_in = 0, fault_supply_ok = 0, err_ack = 0, rec_start = 0;
	logic [15:0] bus_sp = 0, param_wdata = 0;
	logic [3:0] param_addr = 0, rec_rd_idx = 0;
	logic [9:0] ain1_code = 10'h200, ain2_code = 10'h200;
	wire nv_req, nv_we, nv_ack, nv_busy, sol_en, error_out, cable_break, rec_busy, rec_done;
	wire [3:0] nv_addr;
	wire [15:0] nv_wdata, nv_rdata, param_rdata;
	wire [11:0] sol_a_cur, sol_b_cur;
	wire [63:0] rec_rdata;
	int failures = 0, comparisons = 0, cyc = 0, n;
	valve_closed_loop_controller #(.CB_WIN_CYC(32'd50), .CTRL_CYC(32'd8), .REC_AW(4)) dut (
		.ref_clk, .rst_b, .clk_en, .bus_sp_wr, .bus_sp, .param_wr, .param_addr, .param_wdata,
		.param_rdata, .nv_save_req, .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata,
		.nv_busy, .ain1_code, .ain2_code, .fault_in, .fault_supply_ok, .err_ack, .sol_a_cur,
		.sol_b_cur, .sol_en, .error_out, .cable_break, .rec_start, .rec_rd_idx, .rec_rdata,
		.rec_busy, .rec_done);
	nv_store_model nv (.ref_clk, .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task chk(input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task idle(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1;
		@(negedge ref_clk);
		s = 0;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		param_wr = 1;
		param_addr = a;
		param_wdata = d;
		@(negedge ref_clk);
		param_wr = 0;
	endtask
	task rdc(input logic [3:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		param_addr = a;
		idle(2);
		chk(param_rdata, e);
	endtask
	task sp(input logic [15:0] v);
		@(negedge ref_clk);
		bus_sp_wr = 1;
		bus_sp = v;
		@(negedge ref_clk);
		bus_sp_wr = 0;
	endtask
	task wait_idle();
		n = 0;
		while (nv_busy !== 1'b0 && n < 500) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	initial begin
		idle(16);
		rst_b = 1;
		wait_idle();
		chk(nv_busy, 1'b0);
		for (int i = 0; i < 9; i++)
			rdc(4'(i), nv.mem[i]);
		rdc(4'h9, 16'h0);
		wr(4'h3, 16'h0123);
		rdc(4'h3, 16'h0123);
		nv.lat = 3;
		pulse(nv_save_req);
		// Refused while the store transfer runs
		wr(4'h4, 16'h0055);
		wait_idle();
		chk(nv.mem[3], 16'h0123);
		rdc(4'h4, 16'h0);
		wr(4'h0, 16'h0804);
		sp(16'h4000);
		idle(40);
		chk({sol_en, sol_a_cur, sol_b_cur}, {1'b1, 12'h800, 12'h0});
		sp(16'hc000);
		idle(40);
		chk({sol_a_cur, sol_b_cur}, {12'h0, 12'h800});
		clk_en = 0;
		sp(16'h4000);
		idle(20);
		chk(sol_b_cur, 12'h800);
		clk_en = 1;
		for (int m = 0; m < 4; m++) begin
			wr(4'h0, 16'(m));
			sp(16'h2000);
			idle(60);
			chk({sol_a_cur != 12'h0, sol_b_cur}, {1'b1, 12'h0});
			ain2_code = 10'h3ff;
			sp(16'h0);
			idle(60);
			chk({sol_b_cur != 12'h0, sol_a_cur}, {1'b1, 12'h0});
			ain2_code = 10'h200;
		end
		wr(4'h0, 16'h0804);
		wr(4'h1, 16'h0001);
		sp(16'h7fff);
		idle(50);
		chk(sol_a_cur < 12'h100, 1'b1);
		wr(4'h1, 16'h0);
		wr(4'h2, 16'h0001);
		idle(40);
		chk(sol_a_cur, 12'hfff);
		sp(16'h0);
		idle(50);
		chk(sol_a_cur > 12'hf00, 1'b1);
		wr(4'h2, 16'h0);
		for (int i = 0; i < 2; i++) begin
			wr(4'h0, i ? 16'h0014 : 16'h0804);
			ain2_code = 10'h0cc;
			idle(100);
			chk(cable_break, 1'b0);
			ain2_code = 10'h200;
		end
		wr(4'h0, 16'h0814);
		sp(16'h4000);
		ain2_code = 10'h0cc;
		idle(40);
		ain2_code = 10'h0cd;
		idle(1);
		ain2_code = 10'h0cc;
		idle(40);
		chk(cable_break, 1'b0);
		ain2_code = 10'h200;
		idle(2);
		ain2_code = 10'h0cc;
		n = 0;
		while (cable_break !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 49 && n <= 53, 1'b1);
		chk(error_out, 1'b1);
		idle(1);
		chk({sol_a_cur, sol_b_cur}, 24'h0);
		ain2_code = 10'h200;
		pulse(err_ack);
		idle(2);
		chk(cable_break, 1'b0);
		chk(error_out, 1'b0);
		wr(4'h8, 16'h0123);
		wr(4'h0, 16'h0024);
		fault_supply_ok = 1;
		fault_in = 1;
		idle(40);
		chk(sol_a_cur, 12'h123);
		fault_supply_ok = 0;
		idle(40);
		chk(sol_a_cur, 12'h0);
		wr(4'h0, 16'h0004);
		fault_supply_ok = 1;
		idle(40);
		chk(sol_a_cur, 12'h0);
		fault_in = 0;
		idle(40);
		chk(sol_a_cur, 12'h800);
		pulse(rec_start);
		n = 0;
		while (rec_done !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk(rec_done, 1'b1);
		rec_rd_idx = 4'h0;
		idle(2);
		chk(rec_rdata[63:48], 16'h4000);
		chk(rec_busy, 1'b0);
		// Set-point from input 1, 0-20 mA then 4-20 mA range
		wr(4'h0, 16'h010c);
		idle(40);
		chk(sol_a_cur, 12'h800);
		ain1_code = 10'h2cd;
		wr(4'h0, 16'h020c);
		idle(40);
		chk(sol_a_cur, 12'h800);
		ain1_code = 10'h0cc;
		idle(40);
		chk({sol_a_cur, sol_b_cur}, 24'h0);
		wrap_up();
	end
endmodule
